// [hdl/line_ctl_pkg.sv]
// Constants, field layout and carrier types for the line interface control bank.
// Assumes a single clock domain and a host port with one-cycle strobes.
package line_ctl_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map and reset values
	localparam logic [7:0] ADDR_LINE_CTL_1   = 8'h30;
	localparam logic [7:0] ADDR_LINE_CTL_2   = 8'h31;
	localparam logic [7:0] ADDR_TX_BO_GAIN   = 8'h34;
	localparam logic [7:0] LINE_CTL_1_RESET  = 8'h00;
	localparam logic [7:0] LINE_CTL_2_RESET  = 8'h00;
	localparam logic [7:0] TX_BO_GAIN_RESET  = 8'h00;
	localparam logic [7:0] UNMAPPED_RDATA    = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions, first line control register
	localparam int LC1_TX_POWERDOWN_N = 0;
	localparam int LC1_JA_OFF         = 1;
	localparam int LC1_JA_DEPTH       = 2;
	localparam int LC1_JA_SIDE        = 3;
	localparam int LC1_EQ_LIMIT       = 4;
	localparam int LC1_BO_LSB         = 5;
	localparam int LC1_BO_MSB         = 7;

	// Second line control register
	localparam int LC2_CUSTOM_DRV     = 0;
	localparam int LC2_SHORT_OFF      = 1;
	localparam int LC2_PLL_T1         = 3;
	localparam int LC2_ALL_ONES       = 4;
	localparam int LC2_BPV_REQ        = 5;
	localparam int LC2_LI_RESET       = 6;
	localparam int LC2_PLL_128        = 7;

	// Transmit build-out and gain register
	localparam int TBG_GAIN_LSB       = 0;
	localparam int TBG_GAIN_MSB       = 5;
	localparam int TBG_AUTO_GAIN      = 6;

	////////////////////////////////////////////////////////////////////////////
	// Build-out codes and hardware-mode forcing
	localparam logic [2:0] BO_CODE_ZERO     = 3'h0;
	localparam logic [2:0] BO_T1_LAST_VALID = 3'h4;
	localparam logic [2:0] BO_E1_HRL_75     = 3'h4;
	localparam logic [2:0] BO_E1_HRL_120    = 3'h5;
	localparam logic [3:0] HW_LC1_MID_BITS  = 4'h0;
	localparam logic       HW_LC1_TX_ON     = 1'b1;
	localparam logic [1:0] BPV_RUN_LEN      = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Enumerations
	typedef enum logic [1:0] {EQ_T1_36DB, EQ_T1_15DB, EQ_E1_43DB, EQ_E1_12DB} eq_range_t;
	typedef enum logic [1:0] {AREF_DIRECT, AREF_T1_PLL, AREF_128_PLL, AREF_128_T1_PLL} aref_src_t;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic       tx_line_oe;
		logic       ja_enable;
		logic       ja_depth_32;
		logic       ja_in_tx_path;
		eq_range_t  eq_range;
		logic [2:0] build_out_value;
		logic       bo_reserved;
		logic       e1_high_ret_loss;
		logic [5:0] tx_gain_code;
		logic       tx_fixed_gain;
		logic       square_wave_mode;
		logic       open_drain_mode;
		logic       short_limit_on;
		logic       pll_t1_enable;
		logic       pll_128_enable;
		aref_src_t  atten_ref_src;
		logic [1:0] atten_ref_prescale;
		logic       tx_all_ones;
	} line_ctl_t;

endpackage

// [hdl/rise_pulse.sv]
// Rising-edge detector: one-cycle pulse when a control level goes 0 to 1.
// Assumes the level is already synchronous to clk.
`timescale 1ns/10ps
module rise_pulse
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic level,
	output logic      pulse
);

	typedef struct packed {
		logic prev;
		logic pulse;
	} rp_state_t;

	rp_state_t st_q;
	rp_state_t st_d;

	////////////////////////////////////////////////////////////////////////////
	// Next state; a held level gives no repeat pulse
	always_comb
	begin
		st_d       = st_q;
		st_d.prev  = level;
		st_d.pulse = level & ~st_q.prev;
	end

	// Register
	always_ff @(posedge clk)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign pulse = st_q.pulse;

	////////////////////////////////////////////////////////////////////////////
	property p_rise_once;
		@(posedge clk) disable iff (rst)
		(level && $past(level, 2) == 1'b0 && $past(level) && !$past(rst)) |-> pulse ##1 (!pulse || !level);
	endproperty
	a_rise_once: assert property (p_rise_once) else $error("rise pulse missing or repeated");

endmodule

// [hdl/line_interface_control_regs.sv]
// Line interface control register bank: host writes three 8-bit registers,
// the bank decodes them into static controls for the transmitter, jitter
// attenuator, equalizer, reference-clock PLLs and two one-shot requests.
// Assumes host strobes are one cycle, synchronous to clk, never both at once.
//
// Operation
// - control bit 0 low tri-states transmit outputs
// - jitter attenuator off field disables attenuator
// - depth field picks 128 or 32 bits
// - side field places attenuator receive or transmit
// - equalizer limit picks sensitivity per line mode
// - T1 build-out codes above four reserved
// - gain code sets fixed transmitter gain
// - auto gain bit selects automatic or fixed
// - custom driver with code zero: square wave
// - custom driver with nonzero code: open drain
// - limiter off bit disables short-circuit limiter
// - T1 conversion PLL select enables that PLL
// - reference clock source from PLL selects, prescale
// - BPV inserted once at next three ones
// - reset request rise resets recovery, recenters
// - all-ones control low sends unframed ones
// - 12.8MHz PLL select enables that PLL
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module line_interface_control_regs
	import line_ctl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  host_req_t       host_req,
	output logic [7:0]      rdata,
	input  wire logic       hw_mode,
	input  wire logic [2:0] hw_build_out,
	input  wire logic       t1_mode,
	input  wire logic [1:0] master_clk_prescale,
	input  wire logic       tx_bit_valid,
	input  wire logic       tx_bit_one,
	output line_ctl_t       ctl,
	output logic            bpv_insert,
	output logic            line_if_reset
);

	typedef struct packed {
		logic [7:0] line_interface_control_1;
		logic [7:0] line_interface_control_2;
		logic [7:0] tbg;
		logic [7:0] rdata;
		logic       bpv_armed;
		logic [1:0] ones_run;
		logic       bpv_insert;
		line_ctl_t  ctl;
	} bank_state_t;

	bank_state_t st_q;
	bank_state_t st_d;
	logic        bpv_rise;
	logic [7:0]  line_interface_control_1_eff;

	////////////////////////////////////////////////////////////////////////////
	// One-shot requests are edge-triggered so a held bit fires only once
	rise_pulse u_bpv_rise
	(
		.clk   (clk),
		.rst   (rst),
		.level (st_q.line_interface_control_2[LC2_BPV_REQ]),
		.pulse (bpv_rise)
	);

	rise_pulse u_reset_rise
	(
		.clk   (clk),
		.rst   (rst),
		.level (st_q.line_interface_control_2[LC2_LI_RESET]),
		.pulse (line_if_reset)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		st_d = st_q;

		// Register writes; stored bits are kept as written, unused ones included
		if (host_req.wr && host_req.addr == ADDR_LINE_CTL_1)
			st_d.line_interface_control_1 = host_req.wdata;
		else if (host_req.wr && host_req.addr == ADDR_LINE_CTL_2)
			st_d.line_interface_control_2 = host_req.wdata;
		else if (host_req.wr && host_req.addr == ADDR_TX_BO_GAIN)
			st_d.tbg = host_req.wdata;

		// Read data valid the cycle after the strobe only
		if (!host_req.rd)
			st_d.rdata = '0;
		else if (host_req.addr == ADDR_LINE_CTL_1)
			st_d.rdata = st_q.line_interface_control_1;
		else if (host_req.addr == ADDR_LINE_CTL_2)
			st_d.rdata = st_q.line_interface_control_2;
		else if (host_req.addr == ADDR_TX_BO_GAIN)
			st_d.rdata = st_q.tbg;
		else
			st_d.rdata = UNMAPPED_RDATA;

		// Hardware mode: build-out from pins, bits 4..1 zero, transmitter on
		if (hw_mode)
			line_interface_control_1_eff = {hw_build_out, HW_LC1_MID_BITS, HW_LC1_TX_ON};
		else
			line_interface_control_1_eff = st_d.line_interface_control_1;

		// Transmitter and attenuator controls
		st_d.ctl.tx_line_oe    = line_interface_control_1_eff[LC1_TX_POWERDOWN_N];
		st_d.ctl.ja_enable     = ~line_interface_control_1_eff[LC1_JA_OFF];
		st_d.ctl.ja_depth_32   = line_interface_control_1_eff[LC1_JA_DEPTH];
		st_d.ctl.ja_in_tx_path = line_interface_control_1_eff[LC1_JA_SIDE];

		// Equalizer range depends on the line standard
		if (t1_mode)
			st_d.ctl.eq_range = line_interface_control_1_eff[LC1_EQ_LIMIT] ? EQ_T1_15DB : EQ_T1_36DB;
		else
			st_d.ctl.eq_range = line_interface_control_1_eff[LC1_EQ_LIMIT] ? EQ_E1_12DB : EQ_E1_43DB;

		// Build-out code passed on; reserved T1 codes flagged, not remapped
		st_d.ctl.build_out_value  = line_interface_control_1_eff[LC1_BO_MSB:LC1_BO_LSB];
		st_d.ctl.bo_reserved      = t1_mode && (line_interface_control_1_eff[LC1_BO_MSB:LC1_BO_LSB] > BO_T1_LAST_VALID);
		st_d.ctl.e1_high_ret_loss = !t1_mode && (line_interface_control_1_eff[LC1_BO_MSB:LC1_BO_LSB] == BO_E1_HRL_75 ||
			line_interface_control_1_eff[LC1_BO_MSB:LC1_BO_LSB] == BO_E1_HRL_120);

		// Gain: code applies only when automatic gain is off
		st_d.ctl.tx_fixed_gain = st_d.tbg[TBG_AUTO_GAIN];
		if (st_d.tbg[TBG_AUTO_GAIN])
			st_d.ctl.tx_gain_code = st_d.tbg[TBG_GAIN_MSB:TBG_GAIN_LSB];
		else
			st_d.ctl.tx_gain_code = '0;

		// Custom driver splits on whether build-out is zero
		st_d.ctl.square_wave_mode = st_d.line_interface_control_2[LC2_CUSTOM_DRV] &&
			line_interface_control_1_eff[LC1_BO_MSB:LC1_BO_LSB] == BO_CODE_ZERO;
		st_d.ctl.open_drain_mode  = st_d.line_interface_control_2[LC2_CUSTOM_DRV] &&
			line_interface_control_1_eff[LC1_BO_MSB:LC1_BO_LSB] != BO_CODE_ZERO;

		st_d.ctl.short_limit_on = ~st_d.line_interface_control_2[LC2_SHORT_OFF];
		st_d.ctl.tx_all_ones    = ~st_d.line_interface_control_2[LC2_ALL_ONES];

		// PLL selects decoded regardless of attenuator enable, since
		// clock recovery also runs from the reference clock
		st_d.ctl.pll_t1_enable  = st_d.line_interface_control_2[LC2_PLL_T1];
		st_d.ctl.pll_128_enable = st_d.line_interface_control_2[LC2_PLL_128];
		case ({st_d.line_interface_control_2[LC2_PLL_128], st_d.line_interface_control_2[LC2_PLL_T1]})
			2'h0:    st_d.ctl.atten_ref_src = AREF_DIRECT;
			2'h1:    st_d.ctl.atten_ref_src = AREF_T1_PLL;
			2'h2:    st_d.ctl.atten_ref_src = AREF_128_PLL;
			default: st_d.ctl.atten_ref_src = AREF_128_T1_PLL;
		endcase
		st_d.ctl.atten_ref_prescale = master_clk_prescale;

		// BPV: arm on request rise, fire on third consecutive one, disarm
		st_d.bpv_insert = 1'b0;
		if (tx_bit_valid)
		begin
			if (!tx_bit_one)
				st_d.ones_run = '0;
			else if (st_q.ones_run != BPV_RUN_LEN)
				st_d.ones_run = st_q.ones_run + 2'h1;
		end
		if (bpv_rise)
			st_d.bpv_armed = 1'b1;
		else if (st_q.bpv_armed && tx_bit_valid && tx_bit_one &&
			st_d.ones_run == BPV_RUN_LEN)
		begin
			st_d.bpv_armed  = 1'b0;
			st_d.bpv_insert = 1'b1;
			st_d.ones_run   = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset loads zero registers and decoded defaults
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q      <= '0;
			st_q.line_interface_control_1 <= LINE_CTL_1_RESET;
			st_q.line_interface_control_2 <= LINE_CTL_2_RESET;
			st_q.tbg  <= TX_BO_GAIN_RESET;
			st_q.ctl.ja_enable      <= 1'b1;
			st_q.ctl.short_limit_on <= 1'b1;
			st_q.ctl.tx_all_ones    <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from the state register
	assign rdata      = st_q.rdata;
	assign ctl        = st_q.ctl;
	assign bpv_insert = st_q.bpv_insert;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_wr_line_interface_control_1;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_1) |=> st_q.line_interface_control_1 == $past(host_req.wdata);
	endproperty
	a_wr_line_interface_control_1: assert property (p_wr_line_interface_control_1) else $error("first control write not stored");

	property p_read_back;
		@(posedge clk) disable iff (rst)
		(host_req.rd && host_req.addr == ADDR_TX_BO_GAIN && !host_req.wr) |=> rdata == $past(st_q.tbg);
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data differs from stored value");

	property p_powerdown;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_1 && !host_req.wdata[LC1_TX_POWERDOWN_N] && !hw_mode)
		|=> !ctl.tx_line_oe;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("transmitter not tri-stated");

	property p_ja_off;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_1 && !hw_mode)
		|=> ctl.ja_enable == !$past(host_req.wdata[LC1_JA_OFF]) && ctl.ja_depth_32 == $past(host_req.wdata[LC1_JA_DEPTH]);
	endproperty
	a_ja_off: assert property (p_ja_off) else $error("attenuator enable or depth wrong");

	property p_hw_force;
		@(posedge clk) disable iff (rst)
		hw_mode |=> ctl.tx_line_oe && ctl.ja_enable && !ctl.ja_in_tx_path && ctl.build_out_value == $past(hw_build_out);
	endproperty
	a_hw_force: assert property (p_hw_force) else $error("hardware mode forcing wrong");

	property p_custom_drv;
		@(posedge clk) disable iff (rst)
		!(ctl.square_wave_mode && ctl.open_drain_mode) &&
		(ctl.square_wave_mode == 1'b0 || ctl.build_out_value == BO_CODE_ZERO);
	endproperty
	a_custom_drv: assert property (p_custom_drv) else $error("custom driver mode wrong");

	property p_gain;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_TX_BO_GAIN && host_req.wdata[TBG_AUTO_GAIN])
		|=> ctl.tx_fixed_gain && ctl.tx_gain_code == $past(host_req.wdata[TBG_GAIN_MSB:TBG_GAIN_LSB]);
	endproperty
	a_gain: assert property (p_gain) else $error("fixed gain code not applied");

	property p_pll_sel;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_2)
		|=> ctl.pll_t1_enable == $past(host_req.wdata[LC2_PLL_T1]) &&
			ctl.pll_128_enable == $past(host_req.wdata[LC2_PLL_128]) &&
			ctl.tx_all_ones == !$past(host_req.wdata[LC2_ALL_ONES]);
	endproperty
	a_pll_sel: assert property (p_pll_sel) else $error("PLL select or all-ones wrong");

	property p_bpv_once;
		@(posedge clk) disable iff (rst)
		bpv_insert |-> !st_q.bpv_armed ##1 !bpv_insert;
	endproperty
	a_bpv_once: assert property (p_bpv_once) else $error("BPV inserted more than once");

	property p_bpv_needs_arm;
		@(posedge clk) disable iff (rst)
		$rose(bpv_insert) |-> $past(st_q.bpv_armed) && $past(tx_bit_one) && $past(tx_bit_valid);
	endproperty
	a_bpv_needs_arm: assert property (p_bpv_needs_arm) else $error("BPV without request");

	property p_ja_side;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_1 && !hw_mode)
		|=> ctl.ja_in_tx_path == $past(host_req.wdata[LC1_JA_SIDE]);
	endproperty
	a_ja_side: assert property (p_ja_side) else $error("attenuator placement wrong");

	property p_eq_range;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_1 && !hw_mode)
		|=> ctl.eq_range == ($past(t1_mode) ? ($past(host_req.wdata[LC1_EQ_LIMIT]) ? EQ_T1_15DB : EQ_T1_36DB)
			: ($past(host_req.wdata[LC1_EQ_LIMIT]) ? EQ_E1_12DB : EQ_E1_43DB));
	endproperty
	a_eq_range: assert property (p_eq_range) else $error("equalizer range wrong");

	property p_bo_reserved;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_1 && !hw_mode)
		|=> ctl.bo_reserved == ($past(t1_mode) && $past(host_req.wdata[LC1_BO_MSB:LC1_BO_LSB]) > BO_T1_LAST_VALID);
	endproperty
	a_bo_reserved: assert property (p_bo_reserved) else $error("reserved build-out flag wrong");

	property p_high_ret_loss;
		@(posedge clk) disable iff (rst)
		ctl.e1_high_ret_loss |-> !ctl.bo_reserved &&
			(ctl.build_out_value == BO_E1_HRL_75 || ctl.build_out_value == BO_E1_HRL_120);
	endproperty
	a_high_ret_loss: assert property (p_high_ret_loss) else $error("high return loss flag wrong");

	property p_auto_gain;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_TX_BO_GAIN && !host_req.wdata[TBG_AUTO_GAIN])
		|=> !ctl.tx_fixed_gain && ctl.tx_gain_code == 6'h00;
	endproperty
	a_auto_gain: assert property (p_auto_gain) else $error("automatic gain not selected");

	property p_open_drain;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_2 && host_req.wdata[LC2_CUSTOM_DRV] && !hw_mode &&
			st_q.line_interface_control_1[LC1_BO_MSB:LC1_BO_LSB] != BO_CODE_ZERO) |=> ctl.open_drain_mode && !ctl.square_wave_mode;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain mode wrong");

	property p_short_limit;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_2)
		|=> ctl.short_limit_on == !$past(host_req.wdata[LC2_SHORT_OFF]);
	endproperty
	a_short_limit: assert property (p_short_limit) else $error("short-circuit limiter wrong");

	property p_aref_src;
		@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == ADDR_LINE_CTL_2)
		|=> ctl.atten_ref_src == {$past(host_req.wdata[LC2_PLL_128]), $past(host_req.wdata[LC2_PLL_T1])};
	endproperty
	a_aref_src: assert property (p_aref_src) else $error("reference clock source wrong");

	property p_prescale;
		@(posedge clk) disable iff (rst)
		!$past(rst) |-> ctl.atten_ref_prescale == $past(master_clk_prescale);
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescale not passed on");

	property p_lir_pulse;
		@(posedge clk) disable iff (rst)
		$rose(st_q.line_interface_control_2[LC2_LI_RESET]) |=> line_if_reset ##1 !line_if_reset;
	endproperty
	a_lir_pulse: assert property (p_lir_pulse) else $error("line reset pulse wrong");

	property p_bpv_arm;
		@(posedge clk) disable iff (rst)
		$rose(st_q.line_interface_control_2[LC2_BPV_REQ]) |-> ##2 st_q.bpv_armed;
	endproperty
	a_bpv_arm: assert property (p_bpv_arm) else $error("BPV request not armed");

	property p_rdata_idle;
		@(posedge clk) disable iff (rst)
		!host_req.rd |=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

endmodule

// [verif/host_ctl_model.sv]
// Host processor model: issues register writes and reads on the control port.
// Assumes one-cycle strobes sampled on the rising edge of clk, read data one cycle later.
`timescale 1ns/10ps
module host_ctl_model
	import line_ctl_pkg::*;
(
	input  wire logic       clk,
	output host_req_t       req,
	input  wire logic [7:0] rdata
);
	initial req = '0;

	////////////////////////////////////////////////////////////////////////////
	// Unused bits always leave the host as zero
	function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
		clean = d;
		if (a == ADDR_LINE_CTL_2)
			clean[2] = 1'b0;
		if (a == ADDR_TX_BO_GAIN)
			clean[7] = 1'b0;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Idle lines carry the inverse so a stale address or datum cannot pass
	task automatic idle();
		req.wr    <= 1'b0;
		req.rd    <= 1'b0;
		req.addr  <= ~req.addr;
		req.wdata <= ~req.wdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req.wr    <= 1'b1;
		req.addr  <= a;
		req.wdata <= clean(a, d);
		@(posedge clk);
		idle();
	endtask

	// Data taken once the answer has settled after the sampling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req.rd   <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		idle();
		#1;
		d = rdata;
	endtask
endmodule

// [verif/line_interface_control_regs_tb.sv]
// Self-checking bench for the line interface control register bank.
// Assumes the host model in host_ctl_model and a single 40 MHz clock.
`timescale 1ns/10ps
module line_interface_control_regs_tb
	import line_ctl_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	host_req_t  host_req;
	logic [7:0] rdata;
	logic       hw_mode = 1'b0;
	logic [2:0] hw_build_out = 3'h0;
	logic       t1_mode = 1'b0;
	logic [1:0] master_clk_prescale = 2'h0;
	logic       tx_bit_valid = 1'b0;
	logic       tx_bit_one = 1'b0;
	line_ctl_t  ctl;
	logic       bpv_insert;
	logic       line_if_reset;
	int         error_cnt = 0;
	int         tests_run = 0;
	int         bpv_cnt = 0;
	int         lir_cnt = 0;

	host_ctl_model host (.clk(clk), .req(host_req), .rdata(rdata));

	line_interface_control_regs DUT (
		.clk(clk), .rst(rst), .host_req(host_req), .rdata(rdata), .hw_mode(hw_mode),
		.hw_build_out(hw_build_out), .t1_mode(t1_mode), .master_clk_prescale(master_clk_prescale),
		.tx_bit_valid(tx_bit_valid), .tx_bit_one(tx_bit_one), .ctl(ctl), .bpv_insert(bpv_insert),
		.line_if_reset(line_if_reset)
	);

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	// One-shot pulses counted so a repeat or a miss shows up
	always @(posedge clk)
	begin
		if (bpv_insert === 1'b1) bpv_cnt++;
		if (line_if_reset === 1'b1) lir_cnt++;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Transmit bits, first bit in the low position
	task automatic send(input logic [7:0] pat, input int n);
		for (int j = 0; j < n; j++)
		begin
			@(posedge clk);
			tx_bit_valid <= 1'b1;
			tx_bit_one   <= pat[j];
		end
		@(posedge clk);
		tx_bit_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] d;
		host.rd(ADDR_LINE_CTL_1, d); chk(d, LINE_CTL_1_RESET);
		host.rd(ADDR_LINE_CTL_2, d); chk(d, LINE_CTL_2_RESET);
		host.rd(ADDR_TX_BO_GAIN, d); chk(d, TX_BO_GAIN_RESET);
		chk(ctl.tx_line_oe, 0);
		chk(ctl.ja_enable, 1);
		chk(ctl.short_limit_on, 1);
		chk(ctl.tx_all_ones, 1);
	endtask

	// Every first-register value in both line modes
	task automatic t_lc1();
		logic [7:0] v;
		logic [7:0] d;
		logic       t1;
		eq_range_t  e;
		for (int i = 0; i < 512; i++)
		begin
			v = i[7:0];
			t1 = i[8];
			e = t1 ? (v[4] ? EQ_T1_15DB : EQ_T1_36DB) : (v[4] ? EQ_E1_12DB : EQ_E1_43DB);
			@(posedge clk);
			t1_mode <= t1;
			host.wr(ADDR_LINE_CTL_1, v);
			@(negedge clk);
			chk(ctl.tx_line_oe, v[0]);
			chk(ctl.ja_enable, !v[1]);
			chk(ctl.ja_depth_32, v[2]);
			chk(ctl.ja_in_tx_path, v[3]);
			chk(ctl.eq_range, e);
			chk(ctl.build_out_value, v[7:5]);
			chk(ctl.bo_reserved, t1 && v[7:5] > 3'h4);
			chk(ctl.e1_high_ret_loss, !t1 && (v[7:5] == 3'h4 || v[7:5] == 3'h5));
			host.rd(ADDR_LINE_CTL_1, d); chk(d, v);
		end
	endtask

	// Gain code applied only while automatic gain is off
	task automatic t_gain();
		logic [7:0] v;
		logic [7:0] d;
		for (int i = 0; i < 128; i++)
		begin
			v = i[7:0];
			host.wr(ADDR_TX_BO_GAIN, v);
			@(negedge clk);
			chk(ctl.tx_fixed_gain, v[6]);
			chk(ctl.tx_gain_code, v[6] ? v[5:0] : 6'h00);
			host.rd(ADDR_TX_BO_GAIN, d); chk(d, v);
		end
		host.wr(ADDR_TX_BO_GAIN, 8'hff);
		host.rd(ADDR_TX_BO_GAIN, d); chk(d, 8'h7f);
	endtask

	// Driver mode, limiter, PLL selects and reference source
	task automatic t_lc2();
		logic [7:0] v;
		logic       b;
		for (int k = 0; k < 64; k++)
		begin
			b = k[5];
			v = {k[4], 2'b00, k[3], k[2], 1'b0, k[1], k[0]};
			host.wr(ADDR_LINE_CTL_1, b ? 8'h63 : 8'h03); // Attenuator off, PLL selects still set
			master_clk_prescale <= k[2:1];
			host.wr(ADDR_LINE_CTL_2, v);
			@(negedge clk);
			chk(ctl.square_wave_mode, v[0] && !b);
			chk(ctl.open_drain_mode, v[0] && b);
			chk(ctl.short_limit_on, !v[1]);
			chk(ctl.pll_t1_enable, v[3]);
			chk(ctl.pll_128_enable, v[7]);
			chk(ctl.atten_ref_src, {v[7], v[3]});
			chk(ctl.atten_ref_prescale, k[2:1]);
			chk(ctl.tx_all_ones, !v[4]);
		end
	endtask

	// Line reset fires once per rise of the stored bit
	task automatic t_lir();
		lir_cnt = 0;
		host.wr(ADDR_LINE_CTL_2, 8'h40);
		@(posedge clk);
		@(negedge clk);
		chk(line_if_reset, 1);
		repeat (4) @(posedge clk);
		host.wr(ADDR_LINE_CTL_2, 8'h40);
		repeat (4) @(posedge clk);
		chk(lir_cnt, 1);
		host.wr(ADDR_LINE_CTL_2, 8'h00);
		host.wr(ADDR_LINE_CTL_2, 8'h40);
		repeat (4) @(posedge clk);
		chk(lir_cnt, 2);
	endtask

	// One violation per arming, at the third consecutive one
	task automatic t_bpv();
		host.wr(ADDR_LINE_CTL_2, 8'h00);
		bpv_cnt = 0;
		send(8'h0f, 4);
		chk(bpv_cnt, 0);
		host.wr(ADDR_LINE_CTL_2, 8'h20);
		send(8'h06, 3);
		chk(bpv_cnt, 0);
		send(8'h0e, 4);
		chk(bpv_cnt, 1);
		host.wr(ADDR_LINE_CTL_2, 8'h20);
		send(8'h0f, 4);
		chk(bpv_cnt, 1);
		host.wr(ADDR_LINE_CTL_2, 8'h00);
		host.wr(ADDR_LINE_CTL_2, 8'h20);
		send(8'h0e, 4);
		chk(bpv_cnt, 2);
	endtask

	// Pin mode forces the decoded first register, stored value untouched
	task automatic t_hw();
		logic [7:0] d;
		@(posedge clk);
		hw_mode      <= 1'b1;
		hw_build_out <= 3'h5;
		t1_mode      <= 1'b1;
		host.wr(ADDR_LINE_CTL_1, 8'hfe);
		@(negedge clk);
		chk(ctl.tx_line_oe, HW_LC1_TX_ON);
		chk({!ctl.ja_enable, ctl.ja_depth_32, ctl.ja_in_tx_path}, 3'h0);
		chk(ctl.eq_range, EQ_T1_36DB);
		chk(ctl.build_out_value, 3'h5);
		host.rd(ADDR_LINE_CTL_1, d); chk(d, 8'hfe);
		@(posedge clk);
		hw_mode <= 1'b0;
	endtask

	// Unmapped place, and read data that stands one cycle only
	task automatic t_bus();
		logic [7:0] d;
		host.wr(8'h35, 8'h5a);
		host.rd(8'h35, d); chk(d, UNMAPPED_RDATA);
		host.wr(ADDR_LINE_CTL_2, 8'h99);
		host.rd(ADDR_LINE_CTL_2, d); chk(d, 8'h99);
		@(posedge clk);
		#1;
		chk(rdata, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watchdog: full run needs about a twenty-third of this span
	initial
	begin
		#2_000_000;
		error_cnt++;
		conclude();
	end

	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_lc1();
		t_gain();
		t_lc2();
		t_lir();
		t_bpv();
		t_hw();
		t_bus();
		conclude();
	end
endmodule
